//--- core/valley_switch_frequency_reducer.sv
/*
 * Switch-on control of a quasi-resonant flyback controller: start-up
 * hand-off, stepped soft-start ceiling, valley-count counter, zero-crossing
 * counter, ringing suppression, maximum off time and overvoltage latch.
 * Assumes analog comparators outside; switch-off comes from the current
 * comparator as switch_off_i. Needs vsfr_defines.svh and vsfr_pkg.
 */
`include "vsfr_defines.svh"

module valley_switch_frequency_reducer #(
    parameter int EVAL_CYCLES  = `VSFR_EVAL_PERIOD_MS * `VSFR_NS_PER_MS
                                 / `VSFR_CLK_PERIOD_NS,
    parameter int SS_STEP_CYC  = `VSFR_SOFT_START_MS * `VSFR_NS_PER_MS
                                 / `VSFR_CLK_PERIOD_NS
                                 / `VSFR_SOFT_START_STEPS,
    parameter int RING_LONG    = `VSFR_RING_LONG_NS / `VSFR_CLK_PERIOD_NS,
    parameter int RING_SHORT   = `VSFR_RING_SHORT_NS / `VSFR_CLK_PERIOD_NS,
    parameter int OVP_BLANK    = (`VSFR_OVP_BLANK_NS + `VSFR_CLK_PERIOD_NS
                                  - 1) / `VSFR_CLK_PERIOD_NS,
    parameter int MAX_OFF      = (`VSFR_MAX_OFF_NS + `VSFR_CLK_PERIOD_NS
                                  - 1) / `VSFR_CLK_PERIOD_NS
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    input  wire logic       supply_on_i,
    input  wire logic       fb_above_hold_low_i,
    input  wire logic       fb_above_hold_high_i,
    input  wire logic       fb_above_reset_i,
    input  wire logic       line_high_i,
    input  wire logic       valley_below_zc_i,
    input  wire logic       valley_overvoltage_i,
    input  wire logic       valley_below_ringing_i,
    input  wire logic       switch_off_i,
    output logic            gate_drive_o,
    output logic            startup_charge_en_o,
    output logic            soft_start_active_o,
    output logic [9:0]      cs_ceiling_mv_o,
    output logic            hold_sel_high_line_o,
    output logic [2:0]      valley_count_o,
    output logic [2:0]      zc_count_o,
    output logic            latched_off_o
);

    localparam int EW = $clog2(EVAL_CYCLES + 1);
    localparam int SW = $clog2(SS_STEP_CYC + 1);
    localparam int RW = $clog2(RING_LONG + 1);
    localparam int OW = $clog2(MAX_OFF + 1);
    localparam int BW = $clog2(OVP_BLANK + 1);

    if (EVAL_CYCLES < 2 || SS_STEP_CYC < 1 || RING_SHORT < 1 ||
        RING_LONG < RING_SHORT || MAX_OFF <= RING_LONG ||
        OVP_BLANK < 1) begin : g_bad_params
        $error("valley_switch_frequency_reducer: bad timing parameters");
    end

    // Equal ceiling increments; last step lands on the final ceiling
    function automatic logic [9:0] ceiling(input logic [1:0] step);
        logic [19:0] span;
        span = 20'((`VSFR_CEIL_END_MV - `VSFR_CEIL_START_MV) * step);
        return 10'(`VSFR_CEIL_START_MV + span / (`VSFR_SOFT_START_STEPS - 1));
    endfunction

    // Input synchroniser; stage one feeds only stage two
    logic [`VSFR_IN_WIDTH-1:0] meta_ff;
    logic [`VSFR_IN_WIDTH-1:0] sync_ff;
    logic [`VSFR_IN_WIDTH-1:0] raw;
    assign raw = {line_high_i, switch_off_i, valley_below_ringing_i,
                  valley_overvoltage_i, valley_below_zc_i, fb_above_reset_i,
                  fb_above_hold_high_i, fb_above_hold_low_i, supply_on_i};

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else if (ce_i) begin
            meta_ff <= raw;
            sync_ff <= meta_ff;
        end
    end

    logic zc_prev_ff;
    wire supply_on  = sync_ff[`VSFR_IN_SUPPLY_ON];
    wire fb_low     = sync_ff[`VSFR_IN_FB_LOW];
    wire fb_high    = sync_ff[`VSFR_IN_FB_HIGH];
    wire fb_reset   = sync_ff[`VSFR_IN_FB_RESET];
    wire zc_below   = sync_ff[`VSFR_IN_ZC_BELOW];
    wire ovp        = sync_ff[`VSFR_IN_OVP];
    wire ring_below = sync_ff[`VSFR_IN_RING_BELOW];
    wire sw_off     = sync_ff[`VSFR_IN_SWITCH_OFF];
    wire zc_fall    = zc_below & ~zc_prev_ff;

    vsfr_pkg::sw_state_type state_ff;
    vsfr_pkg::sw_state_type nxt_state;
    logic [RW-1:0] ring_ff;
    logic [OW-1:0] off_ff;
    logic [BW-1:0] blank_ff;
    logic [2:0]    zc_ff;
    logic [2:0]    valley_ff;

    wire gate_off    = (state_ff == vsfr_pkg::ST_SUPPRESS) ||
                       (state_ff == vsfr_pkg::ST_VALLEY);
    wire max_off_hit = (off_ff >= OW'(MAX_OFF));
    wire valley_hit  = (zc_ff >= valley_ff);
    wire ovp_trip    = gate_off && ovp && (blank_ff >= BW'(OVP_BLANK - 1));
    wire ring_done   = (ring_ff == '0);
    wire [RW-1:0] ring_load = ring_below ? RW'(RING_LONG)
                                         : RW'(RING_SHORT);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            vsfr_pkg::ST_STARTUP:
                if (supply_on) nxt_state = vsfr_pkg::ST_ON;
            vsfr_pkg::ST_ON:
                if (sw_off) nxt_state = vsfr_pkg::ST_SUPPRESS;
            vsfr_pkg::ST_SUPPRESS:
                if (ovp_trip) nxt_state = vsfr_pkg::ST_LATCHED;
                else if (ring_done) nxt_state = vsfr_pkg::ST_VALLEY;
            vsfr_pkg::ST_VALLEY:
                if (ovp_trip) nxt_state = vsfr_pkg::ST_LATCHED;
                else if (valley_hit || max_off_hit) begin
                    nxt_state = vsfr_pkg::ST_ON;
                end
            vsfr_pkg::ST_LATCHED:
                nxt_state = vsfr_pkg::ST_LATCHED;
            default:
                nxt_state = vsfr_pkg::ST_LATCHED;
        endcase
    end

    wire gate_rise = (nxt_state == vsfr_pkg::ST_ON) &&
                     (state_ff != vsfr_pkg::ST_ON);
    wire enter_off = (nxt_state == vsfr_pkg::ST_SUPPRESS) &&
                     (state_ff == vsfr_pkg::ST_ON);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff            <= vsfr_pkg::ST_STARTUP;
            gate_drive_o        <= 1'b0;
            startup_charge_en_o <= 1'b1;
            latched_off_o       <= 1'b0;
            zc_prev_ff          <= 1'b0;
        end else if (ce_i) begin
            state_ff            <= nxt_state;
            gate_drive_o        <= (nxt_state == vsfr_pkg::ST_ON);
            startup_charge_en_o <= (nxt_state == vsfr_pkg::ST_STARTUP);
            latched_off_o       <= (nxt_state == vsfr_pkg::ST_LATCHED);
            zc_prev_ff          <= zc_below;
        end
    end

    // Ringing, off-time and overvoltage blanking timers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ring_ff  <= '0;
            off_ff   <= '0;
            blank_ff <= '0;
        end else if (ce_i) begin
            if (enter_off) ring_ff <= ring_load;
            else if (!ring_done) ring_ff <= ring_ff - RW'(1);
            if (!gate_off) off_ff <= '0;
            else if (!max_off_hit) off_ff <= off_ff + OW'(1);
            // Blanking restarts if the overvoltage clears early
            if (gate_off && ovp) blank_ff <= blank_ff + BW'(1);
            else blank_ff <= '0;
        end
    end

    // Zero crossings count from turn-off, also during suppression
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            zc_ff <= '0;
        end else if (ce_i) begin
            if (gate_rise) zc_ff <= '0;
            else if (gate_off && zc_fall && zc_ff != `VSFR_ZC_MAX) begin
                zc_ff <= zc_ff + 3'h1;
            end
        end
    end
    assign zc_count_o = zc_ff;

    // Soft-start: four equal steps from turn-on
    logic [SW-1:0] ss_cnt_ff;
    logic [1:0]    ss_step_ff;
    logic          ss_run_ff;
    wire ss_tick = ss_run_ff && (ss_cnt_ff == SW'(SS_STEP_CYC - 1));

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ss_cnt_ff           <= '0;
            ss_step_ff          <= '0;
            ss_run_ff           <= 1'b0;
            soft_start_active_o <= 1'b0;
            cs_ceiling_mv_o     <= `VSFR_CEIL_START_MV;
        end else if (ce_i) begin
            if (state_ff == vsfr_pkg::ST_STARTUP && supply_on) begin
                ss_run_ff           <= 1'b1;
                soft_start_active_o <= 1'b1;
            end else if (ss_tick) begin
                ss_cnt_ff <= '0;
                if (ss_step_ff == 2'h3) begin
                    ss_run_ff           <= 1'b0;
                    soft_start_active_o <= 1'b0;
                end else begin
                    ss_step_ff      <= ss_step_ff + 2'h1;
                    cs_ceiling_mv_o <= ceiling(ss_step_ff + 2'h1);
                end
            end else if (ss_run_ff) begin
                ss_cnt_ff <= ss_cnt_ff + SW'(1);
            end
        end
    end

    // Valley-count evaluation period with sticky feedback flags
    logic [EW-1:0] eval_ff;
    logic          seen_low_ff;
    logic          seen_high_ff;
    logic          seen_reset_ff;
    wire eval_end  = (eval_ff == EW'(EVAL_CYCLES - 1));
    wire any_low   = seen_low_ff | fb_low;
    wire any_high  = seen_high_ff | fb_high;
    wire any_reset = seen_reset_ff | fb_reset;

    logic [2:0] nxt_valley;
    always_comb begin
        nxt_valley = valley_ff;
        if (any_reset) nxt_valley = `VSFR_VALLEY_MIN;
        else if (any_high) begin
            if (valley_ff != `VSFR_VALLEY_MIN) begin
                nxt_valley = valley_ff - 3'h1;
            end
        end else if (!any_low) begin
            if (valley_ff != `VSFR_VALLEY_MAX) begin
                nxt_valley = valley_ff + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            eval_ff              <= '0;
            seen_low_ff          <= 1'b0;
            seen_high_ff         <= 1'b0;
            seen_reset_ff        <= 1'b0;
            valley_ff            <= `VSFR_VALLEY_MIN;
            hold_sel_high_line_o <= 1'b0;
        end else if (ce_i) begin
            hold_sel_high_line_o <= sync_ff[`VSFR_IN_LINE_HIGH];
            if (state_ff == vsfr_pkg::ST_STARTUP) begin
                eval_ff   <= '0;
                valley_ff <= `VSFR_VALLEY_MIN;
            end else if (eval_end) begin
                eval_ff       <= '0;
                valley_ff     <= nxt_valley;
                // New period starts clean; no sample is dropped
                seen_low_ff   <= 1'b0;
                seen_high_ff  <= 1'b0;
                seen_reset_ff <= 1'b0;
            end else begin
                eval_ff       <= eval_ff + EW'(1);
                seen_low_ff   <= any_low;
                seen_high_ff  <= any_high;
                seen_reset_ff <= any_reset;
            end
        end
    end
    assign valley_count_o = valley_ff;

endmodule

//--- core/vsfr_defines.svh
/*
 * Constants for the valley-switch frequency reducer: timing in its own
 * units, soft-start ceiling figures, valley-count limits, input bit map.
 * Assumes a single 100 MHz clock; included by bare name.
 */
// What this block does
// - Supply above turn-on level stops start-up charging and starts soft-start.
// - Soft-start lasts 12 ms in four equal steps, ceiling 0.32 V to 1 V.
// - Valley count is judged against three feedback levels every 48 ms period.
// - Feedback always below hold-low level: valley count up by one, max 7.
// - Above hold-low but never above hold-high: valley count unchanged.
// - Above hold-high but never above reset level: count down by one, min 1.
// - Feedback above reset level forces valley count to 1.
// - Valley count stays within 1 to 7; out-of-range steps are ignored.
// - Valley count starts at 1 after start-up.
// - Hold thresholds are selected by the detected line voltage level.
// - Each falling valley-sense crossing after turn-off bumps zero count, 0..7.
// - Zero-crossing count clears whenever the gate drive goes high.
// - Overvoltage during off-time latches off after a fixed blanking time.
// - Ringing suppression is long below ringing level, short otherwise.
// - Gate drive stays low while ringing suppression runs.
// - After suppression, gate turns on when zero count reaches valley count.
// - Gate turns on regardless after the maximum off interval.
`ifndef VSFR_DEFINES_SVH
`define VSFR_DEFINES_SVH

`define VSFR_CLK_PERIOD_NS     10
`define VSFR_EVAL_PERIOD_MS    48
`define VSFR_SOFT_START_MS     12
`define VSFR_SOFT_START_STEPS  4
`define VSFR_RING_LONG_NS      10000
`define VSFR_RING_SHORT_NS     2500
`define VSFR_OVP_BLANK_NS      1000
`define VSFR_MAX_OFF_NS        50000
`define VSFR_NS_PER_MS         1000000

`define VSFR_CEIL_START_MV     10'h140
`define VSFR_CEIL_END_MV       10'h3e8

`define VSFR_VALLEY_MIN        3'h1
`define VSFR_VALLEY_MAX        3'h7
`define VSFR_ZC_MAX            3'h7

// Bit positions in the synchronised comparator vector
`define VSFR_IN_SUPPLY_ON      0
`define VSFR_IN_FB_LOW         1
`define VSFR_IN_FB_HIGH        2
`define VSFR_IN_FB_RESET       3
`define VSFR_IN_ZC_BELOW       4
`define VSFR_IN_OVP            5
`define VSFR_IN_RING_BELOW     6
`define VSFR_IN_SWITCH_OFF     7
`define VSFR_IN_LINE_HIGH      8
`define VSFR_IN_WIDTH          9

`endif

//--- core/vsfr_pkg.sv
/*
 * Types for the valley-switch frequency reducer.
 * Assumes nothing beyond a SystemVerilog elaborator.
 */
package vsfr_pkg;

    typedef enum logic [4:0] {
        ST_STARTUP  = 5'h01,
        ST_ON       = 5'h02,
        ST_SUPPRESS = 5'h04,
        ST_VALLEY   = 5'h08,
        ST_LATCHED  = 5'h10
    } sw_state_type;

endpackage

//--- verification/tb.sv
/* Bench for the valley-switch frequency reducer: feedback levels per
   evaluation period, a power-stage model closes the switching loop.
   Assumes the design files and the checker are compiled first. */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int EVAL = 64;
    localparam int SS   = 16;
    localparam int RL   = 8;
    localparam int RS   = 4;
    localparam int OB   = 3;
    localparam int MO   = 32;
    logic       clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic       ce = 1'b1;
    logic       supply = 1'b0;
    logic [2:0] fb = 3'h0;
    logic       line = 1'b0;
    logic       ring = 1'b0;
    logic       damp = 1'b0;
    logic       ovp = 1'b0;
    logic       sw_off, below_zc, overv, gate, charge, ss, sel, latched;
    logic [9:0] ceil;
    logic [2:0] valley, zc, vp;
    logic [2:0] seen = 3'h1;
    logic [2:0] v = 3'h2;
    logic [2:0] q[$];
    logic [2:0] pats [11] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0,
                              3'h1, 3'h3, 3'h3, 3'h7, 3'h3};
    int         err_count = 0;
    int         n_tests = 0;
    int         seed = 43298;
    int         k, w;

    valley_switch_frequency_reducer #(.EVAL_CYCLES(EVAL), .SS_STEP_CYC(SS),
        .RING_LONG(RL), .RING_SHORT(RS), .OVP_BLANK(OB), .MAX_OFF(MO)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .supply_on_i(supply),
        .fb_above_hold_low_i(fb[0]), .fb_above_hold_high_i(fb[1]),
        .fb_above_reset_i(fb[2]), .line_high_i(line),
        .valley_below_zc_i(below_zc), .valley_overvoltage_i(overv),
        .valley_below_ringing_i(ring), .switch_off_i(sw_off),
        .gate_drive_o(gate), .startup_charge_en_o(charge),
        .soft_start_active_o(ss), .cs_ceiling_mv_o(ceil),
        .hold_sel_high_line_o(sel), .valley_count_o(valley),
        .zc_count_o(zc), .latched_off_o(latched));
    vsfr_stage stage (.clk_i(clk_i), .gate_drive_i(gate), .damp_i(damp),
        .ovp_i(ovp), .switch_off_o(sw_off), .below_zc_o(below_zc),
        .overvoltage_o(overv));

    initial forever #5 clk_i = ~clk_i;

    task automatic close_out();
        if (err_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t: got %0d expected %0d", $time, got, exp);
        end
    endtask

    function automatic logic [2:0] nxt_val(logic [2:0] c, logic [2:0] f);
        if (f[2]) return 3'h1;
        if (f[1]) return (c == 3'h1) ? c : c - 3'h1;
        if (f[0]) return c;
        return (c == 3'h7) ? c : c + 3'h1;
    endfunction

    // Each valley count change takes the oldest expectation
    always @(negedge clk_i) begin
        if (!rst_i && valley !== seen) begin
            seen = valley;
            n_tests++;
            if (q.size() == 0 || q[0] !== seen) begin
                err_count++;
                $display("Error %0t: valley count %0d", $time, seen);
            end
            if (q.size() > 0) void'(q.pop_front());
        end
    end

    initial begin
        repeat (8) @(negedge clk_i);
        rst_i = 1'b0;
        chk(valley, 3'h1);
        chk(charge, 1'b1);
        repeat (4) @(negedge clk_i);
        // Enable low: the raised supply must not be acted on yet
        ce = 1'b0;
        supply = 1'b1;
        repeat (6) @(negedge clk_i);
        chk({ss, charge}, 2'h1);
        ce = 1'b1;
        q.push_back(3'h2);
        fork
            for (k = 0; k < 4; k++) begin
                repeat (k == 0 ? 6 : SS) @(negedge clk_i);
                if (k == 0) chk({ss, charge}, 2'h2);
                chk(ceil, 10'(10'h140 + 10'h2a8 * k / 3));
            end
            for (w = 0; w < 200 && q.size() > 0; w++) @(negedge clk_i);
        join
        chk(10'(q.size()), 10'h0);
        // Switch levels just after a period boundary; leaks are harmless
        for (k = 0; k < 11; k++) begin
            fb = pats[k];
            ring = k[0];
            damp = (k == 4);
            line = 1'($random(seed));
            vp = v;
            v = nxt_val(v, pats[k]);
            if (v !== vp) q.push_back(v);
            repeat (EVAL) @(negedge clk_i);
        end
        repeat (8) @(negedge clk_i);
        chk(10'(q.size()), 10'h0);
        ovp = 1'b1;
        for (w = 0; w < 300 && latched !== 1'b1; w++) @(negedge clk_i);
        chk(latched, 1'b1);
        repeat (40) @(negedge clk_i);
        chk(gate, 1'b0);
        close_out();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        close_out();
    end
endmodule

bind valley_switch_frequency_reducer vsfr_sva #(
    .SS_STEP_CYC(SS_STEP_CYC), .MAX_OFF(MAX_OFF),
    .RING_LONG(RING_LONG)) u_sva (
    .clk_i(clk_i), .rst_i(rst_i), .line_high_i(line_high_i),
    .valley_below_ringing_i(valley_below_ringing_i),
    .gate_drive_o(gate_drive_o), .startup_charge_en_o(startup_charge_en_o),
    .soft_start_active_o(soft_start_active_o),
    .cs_ceiling_mv_o(cs_ceiling_mv_o),
    .hold_sel_high_line_o(hold_sel_high_line_o),
    .valley_count_o(valley_count_o), .zc_count_o(zc_count_o),
    .latched_off_o(latched_off_o));

//--- verification/vsfr_stage.sv
/* Flyback power-stage stand-in: ends each on-time, rings the valley
   sense comparator after turn-off, raises overvoltage on request.
   Assumes the bench sets damping and overvoltage modes. */
module vsfr_stage (
    input  wire logic clk_i,
    input  wire logic gate_drive_i,
    input  wire logic damp_i,
    input  wire logic ovp_i,
    output logic      switch_off_o = 1'b0,
    output logic      below_zc_o = 1'b1,
    output logic      overvoltage_o = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    int   t = 0;
    logic g = 1'b0;

    // Moves on the falling edge, clear of the design's sampling
    always @(negedge clk_i) begin
        t = (gate_drive_i == g) ? t + 1 : 0;
        g = gate_drive_i;
        switch_off_o <= g && t >= 6;
        // Clamped low while on; a damped tank gives no crossings
        below_zc_o <= g || (!damp_i && t[1]);
        overvoltage_o <= ovp_i && !g && t < 12;
    end
endmodule

//--- verification/vsfr_sva.sv
/* Port checker for the valley-switch frequency reducer.
   Assumes ce_i high outside start-up; bound into the design from the
   bench. */
module vsfr_sva #(
    parameter int SS_STEP_CYC = 16,
    parameter int MAX_OFF     = 32,
    parameter int RING_LONG   = 8
) (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       line_high_i,
    input wire logic       valley_below_ringing_i,
    input wire logic       gate_drive_o,
    input wire logic       startup_charge_en_o,
    input wire logic       soft_start_active_o,
    input wire logic [9:0] cs_ceiling_mv_o,
    input wire logic       hold_sel_high_line_o,
    input wire logic [2:0] valley_count_o,
    input wire logic [2:0] zc_count_o,
    input wire logic       latched_off_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Longest suppression plus synchroniser and register latency
    localparam int ON_WIN = RING_LONG + 3;
    int        off_cnt;
    int        ss_cnt;
    wire logic off_clr = gate_drive_o | latched_off_o | startup_charge_en_o;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Counters bound the windows too long for repetition
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            off_cnt <= 0;
            ss_cnt  <= 0;
        end else begin
            off_cnt <= off_clr ? 0 : off_cnt + 1;
            ss_cnt  <= soft_start_active_o ? ss_cnt + 1 : 0;
        end
    end

    a_charge_handoff: assert property (
        $fell(startup_charge_en_o) |-> gate_drive_o && soft_start_active_o)
        else $error("charge path dropped without switching");
    a_ss_ramp_end: assert property (
        $fell(soft_start_active_o) |-> cs_ceiling_mv_o == 10'h3e8
        && ss_cnt >= 4 * SS_STEP_CYC - 2 && ss_cnt <= 4 * SS_STEP_CYC + 2)
        else $error("soft-start ramp length or end ceiling wrong");
    a_valley_step: assert property (
        $changed(valley_count_o) |-> valley_count_o == 3'h1
        || valley_count_o == $past(valley_count_o) + 3'h1
        || valley_count_o == $past(valley_count_o) - 3'h1)
        else $error("valley count jumped");
    a_valley_range: assert property (valley_count_o != 3'h0)
        else $error("valley count left its range");
    a_line_select: assert property (
        $stable(line_high_i) [*6] |-> hold_sel_high_line_o == line_high_i)
        else $error("hold threshold select does not follow line");
    a_zc_step: assert property (
        $changed(zc_count_o) && zc_count_o != 3'h0 |-> !gate_drive_o
        && zc_count_o == $past(zc_count_o) + 3'h1)
        else $error("zero count stepped wrongly");
    a_zc_clear: assert property ($rose(gate_drive_o) |=> zc_count_o == 3'h0)
        else $error("zero count not cleared at turn-on");
    a_latch_hold: assert property (
        latched_off_o |=> latched_off_o && !gate_drive_o)
        else $error("latch-off released or gate driven");
    a_long_ring: assert property (
        $fell(gate_drive_o) && valley_below_ringing_i
        && $past(valley_below_ringing_i, 4) |-> !gate_drive_o [*8])
        else $error("long suppression cut short");
    a_ring_block: assert property ($fell(gate_drive_o) |-> !gate_drive_o [*4])
        else $error("gate back on during suppression");
    a_valley_on: assert property (
        !gate_drive_o && !latched_off_o && !startup_charge_en_o
        && zc_count_o >= valley_count_o
        |-> ##[0:ON_WIN] (gate_drive_o || latched_off_o))
        else $error("gate not turned on at valley count");
    a_max_off: assert property (off_cnt <= MAX_OFF + 4)
        else $error("gate off beyond maximum off interval");

    cover property ($rose(latched_off_o));
    cover property (valley_count_o == 3'h7);
    cover property (off_cnt == MAX_OFF);
endmodule
